/* src/omrx_exec.sv */
// instruction execution core for the or, move, rotate and return subset
// assumes an avalon-mm master on clk; writing the instruction register
// executes one instruction in the cycle the write is accepted
//
// Behaviour
// - or literal into work: work |= literal, only zero flag updated
// - load literal into work: work = literal, no flags change
// - load literal accepted whatever the don't-care bits hold, zeros too
// - or work with file: work | file, routed by direction, zero updated
// - direction 0 writes work, direction 1 writes the file register
// - store work to file copies work into file, no flags change
// - move file register to destination, zero updated, acts as zero test
// - return from interrupt: pc from top of stack, interrupt enable set
// - rotate left through carry, routed by direction, only carry updated
`timescale 1ns/10ps
`include "omrx_regs.svh"
module omrx_exec #(
  parameter int FILE_DEPTH = 128
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire omrx_pkg::omrx_avl_req_t avl_req,
  output omrx_pkg::omrx_avl_rsp_t     avl_rsp
);
  import omrx_pkg::*;

  logic [7:0]                 file_mem [FILE_DEPTH];
  logic [7:0]                 work_reg;
  logic                       zero_reg;
  logic                       carry_reg;
  logic                       int_en_reg;
  logic                       bad_reg;
  logic [`OMRX_PC_W-1:0]      pc_reg;
  logic [`OMRX_PC_W-1:0]      stack_top_reg;
  logic [`OMRX_INSTR_W-1:0]   instr_reg;
  logic [`OMRX_FADDR_W-1:0]   faddr_reg;
  logic                       waitrequest_reg;
  logic [`OMRX_DATA_W-1:0]    readdata_reg;

  logic                       req;
  logic                       accept;
  logic                       wr_acc;
  logic                       exec;
  logic [`OMRX_INSTR_W-1:0]   instr;
  omrx_op_t                   op;
  logic [`OMRX_FADDR_W-1:0]   f_idx;
  logic                       dir;
  logic [7:0]                 f_val;
  logic [7:0]                 result;
  logic                       res_to_w;
  logic                       res_to_f;
  logic                       upd_zero;
  logic                       upd_carry;
  logic                       carry_next;
  logic [`OMRX_DATA_W-1:0]    rd_next;

  function automatic logic opm(input logic [`OMRX_INSTR_W-1:0] i,
                               input logic [`OMRX_INSTR_W-1:0] m,
                               input logic [`OMRX_INSTR_W-1:0] v);
    return (i & m) == v;
  endfunction

  function automatic omrx_op_t decode(input logic [`OMRX_INSTR_W-1:0] i);
    if (opm(i, `OMRX_MASK_OR_LIT, `OMRX_MATCH_OR_LIT))
      return OMRX_OP_OR_LIT;
    else if (opm(i, `OMRX_MASK_LD_LIT, `OMRX_MATCH_LD_LIT))
      return OMRX_OP_LD_LIT;
    else if (opm(i, `OMRX_MASK_OR_FILE, `OMRX_MATCH_OR_FILE))
      return OMRX_OP_OR_F;
    else if (opm(i, `OMRX_MASK_ST_WORK, `OMRX_MATCH_ST_WORK))
      return OMRX_OP_ST_W;
    else if (opm(i, `OMRX_MASK_MV_FILE, `OMRX_MATCH_MV_FILE))
      return OMRX_OP_MV_F;
    else if (opm(i, `OMRX_MASK_ROT_L, `OMRX_MATCH_ROT_L))
      return OMRX_OP_ROT_L;
    else if (opm(i, `OMRX_MASK_RET_INT, `OMRX_MATCH_RET_INT))
      return OMRX_OP_RET_I;
    else
      return OMRX_OP_NONE;
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    return v == `OMRX_RST_W8;
  endfunction

  // a request is answered on the cycle after it is first seen
  assign req    = avl_req.read | avl_req.write;
  assign accept = req & ~waitrequest_reg;
  assign wr_acc = accept & avl_req.write;
  assign exec   = wr_acc & (avl_req.address == `OMRX_OFF_INSTR);
  assign instr  = avl_req.writedata[`OMRX_INSTR_W-1:0];
  assign op     = decode(instr);
  assign f_idx  = instr[`OMRX_FADDR_W-1:0];
  assign dir    = instr[`OMRX_DIR_BIT];
  assign f_val  = file_mem[f_idx];

  always_comb begin
    result     = work_reg;
    res_to_w   = 1'b0;
    res_to_f   = 1'b0;
    upd_zero   = 1'b0;
    upd_carry  = 1'b0;
    carry_next = carry_reg;
    case (op)
      OMRX_OP_OR_LIT: begin
        result   = work_reg | instr[7:0];
        res_to_w = 1'b1;
        upd_zero = 1'b1;
      end
      OMRX_OP_LD_LIT: begin
        result   = instr[7:0];
        res_to_w = 1'b1;
      end
      OMRX_OP_OR_F: begin
        result   = work_reg | f_val;
        res_to_w = ~dir;
        res_to_f = dir;
        upd_zero = 1'b1;
      end
      OMRX_OP_ST_W: begin
        result   = work_reg;
        res_to_f = 1'b1;
      end
      OMRX_OP_MV_F: begin
        result   = f_val;
        res_to_w = ~dir;
        res_to_f = dir;
        upd_zero = 1'b1;
      end
      OMRX_OP_ROT_L: begin
        result     = {f_val[6:0], carry_reg};
        carry_next = f_val[7];
        res_to_w   = ~dir;
        res_to_f   = dir;
        upd_carry  = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // file registers: written by execution or through the data window
  always_ff @(posedge clk) begin
    if (exec && res_to_f)
      file_mem[f_idx] <= result;
    else if (wr_acc && avl_req.address == `OMRX_OFF_FDATA)
      file_mem[faddr_reg] <= avl_req.writedata[7:0];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      work_reg <= `OMRX_RST_W8;
    else if (exec && res_to_w)
      work_reg <= result;
    else if (wr_acc && avl_req.address == `OMRX_OFF_WORK)
      work_reg <= avl_req.writedata[7:0];
  end

  // status flags; execution and a status write never share a cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_reg  <= 1'b0;
      carry_reg <= 1'b0;
      int_en_reg <= 1'b0;
      bad_reg   <= 1'b0;
    end else if (exec) begin
      if (upd_zero)
        zero_reg <= is_zero(result);
      if (upd_carry)
        carry_reg <= carry_next;
      if (op == OMRX_OP_RET_I)
        int_en_reg <= 1'b1;
      if (op == OMRX_OP_NONE && !opm(instr, `OMRX_MASK_NOP,
                                     `OMRX_MATCH_NOP))
        bad_reg <= 1'b1;
    end else if (wr_acc && avl_req.address == `OMRX_OFF_STATUS) begin
      zero_reg  <= avl_req.writedata[`OMRX_ST_ZERO];
      carry_reg <= avl_req.writedata[`OMRX_ST_CARRY];
      int_en_reg <= avl_req.writedata[`OMRX_ST_INT_EN];
      // unknown-opcode flag is write-one-to-clear
      if (avl_req.writedata[`OMRX_ST_BAD])
        bad_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg    <= `OMRX_RST_PC;
      instr_reg <= `OMRX_RST_INSTR;
    end else if (exec) begin
      instr_reg <= instr;
      if (op == OMRX_OP_RET_I)
        pc_reg <= stack_top_reg;
      else
        pc_reg <= pc_reg + `OMRX_PC_STEP;
    end else if (wr_acc && avl_req.address == `OMRX_OFF_PC) begin
      pc_reg <= avl_req.writedata[`OMRX_PC_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stack_top_reg <= `OMRX_RST_PC;
      faddr_reg <= `OMRX_RST_FADDR;
    end else if (wr_acc) begin
      if (avl_req.address == `OMRX_OFF_STACK_TOP)
        stack_top_reg <= avl_req.writedata[`OMRX_PC_W-1:0];
      else if (avl_req.address == `OMRX_OFF_FADDR)
        faddr_reg <= avl_req.writedata[`OMRX_FADDR_W-1:0];
    end
  end

  always_comb begin
    rd_next = '0;
    if (avl_req.address == `OMRX_OFF_INSTR)
      rd_next[`OMRX_INSTR_W-1:0] = instr_reg;
    else if (avl_req.address == `OMRX_OFF_WORK)
      rd_next[7:0] = work_reg;
    else if (avl_req.address == `OMRX_OFF_STATUS) begin
      rd_next[`OMRX_ST_ZERO]  = zero_reg;
      rd_next[`OMRX_ST_CARRY] = carry_reg;
      rd_next[`OMRX_ST_INT_EN] = int_en_reg;
      rd_next[`OMRX_ST_BAD]   = bad_reg;
    end else if (avl_req.address == `OMRX_OFF_PC)
      rd_next[`OMRX_PC_W-1:0] = pc_reg;
    else if (avl_req.address == `OMRX_OFF_STACK_TOP)
      rd_next[`OMRX_PC_W-1:0] = stack_top_reg;
    else if (avl_req.address == `OMRX_OFF_FADDR)
      rd_next[`OMRX_FADDR_W-1:0] = faddr_reg;
    else if (avl_req.address == `OMRX_OFF_FDATA)
      rd_next[7:0] = file_mem[faddr_reg];
  end

  // one wait cycle per access; read data captured while waiting
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest_reg <= 1'b1;
      readdata_reg    <= '0;
    end else begin
      waitrequest_reg <= ~(req & waitrequest_reg);
      if (avl_req.read && waitrequest_reg)
        readdata_reg <= rd_next;
    end
  end

  assign avl_rsp.readdata    = readdata_reg;
  assign avl_rsp.waitrequest = waitrequest_reg;

endmodule

/* inc/omrx_regs.svh */
// register offsets, field positions, reset values and opcode patterns
// assumes inclusion by bare name from the package and the design file
`ifndef OMRX_REGS_SVH
`define OMRX_REGS_SVH

`define OMRX_ADDR_W        5
`define OMRX_DATA_W        32
`define OMRX_INSTR_W       14
`define OMRX_PC_W          13
`define OMRX_FADDR_W       7

`define OMRX_OFF_INSTR     5'h00
`define OMRX_OFF_WORK      5'h04
`define OMRX_OFF_STATUS    5'h08
`define OMRX_OFF_PC        5'h0c
`define OMRX_OFF_STACK_TOP 5'h10
`define OMRX_OFF_FADDR     5'h14
`define OMRX_OFF_FDATA     5'h18

`define OMRX_ST_ZERO       0
`define OMRX_ST_CARRY      1
`define OMRX_ST_INT_EN     2
`define OMRX_ST_BAD        3
`define OMRX_ST_W          4

`define OMRX_RST_W8        8'h00
`define OMRX_RST_PC        13'h0000
`define OMRX_RST_INSTR     14'h0000
`define OMRX_RST_FADDR     7'h00
`define OMRX_PC_STEP       13'h0001

`define OMRX_DIR_BIT       7

`define OMRX_MASK_OR_LIT   14'h3f00
`define OMRX_MATCH_OR_LIT  14'h3800
`define OMRX_MASK_LD_LIT   14'h3c00
`define OMRX_MATCH_LD_LIT  14'h3000
`define OMRX_MASK_OR_FILE  14'h3f00
`define OMRX_MATCH_OR_FILE 14'h0400
`define OMRX_MASK_ST_WORK  14'h3f80
`define OMRX_MATCH_ST_WORK 14'h0080
`define OMRX_MASK_MV_FILE  14'h3f00
`define OMRX_MATCH_MV_FILE 14'h0800
`define OMRX_MASK_ROT_L    14'h3f00
`define OMRX_MATCH_ROT_L   14'h0d00
`define OMRX_MASK_RET_INT  14'h3fff
`define OMRX_MATCH_RET_INT 14'h0009
`define OMRX_MASK_NOP      14'h3f9f
`define OMRX_MATCH_NOP     14'h0000

`endif

/* inc/omrx_pkg.sv */
// types shared by the execution block and its bench
// assumes omrx_regs.svh is on the include path
`include "omrx_regs.svh"
package omrx_pkg;

  typedef enum logic [7:0] {
    OMRX_OP_NONE   = 8'h01,
    OMRX_OP_OR_LIT = 8'h02,
    OMRX_OP_LD_LIT = 8'h04,
    OMRX_OP_OR_F   = 8'h08,
    OMRX_OP_ST_W   = 8'h10,
    OMRX_OP_MV_F   = 8'h20,
    OMRX_OP_ROT_L  = 8'h40,
    OMRX_OP_RET_I  = 8'h80
  } omrx_op_t;

  typedef struct packed {
    logic                       read;
    logic                       write;
    logic [`OMRX_ADDR_W-1:0]    address;
    logic [`OMRX_DATA_W-1:0]    writedata;
  } omrx_avl_req_t;

  typedef struct packed {
    logic [`OMRX_DATA_W-1:0]    readdata;
    logic                       waitrequest;
  } omrx_avl_rsp_t;

endpackage

/* testbench/omrx_exec_sva.sv */
// assertions on the bus ports of the execution block
// assumes a bind to omrx_exec and a single clock domain
`timescale 1ns/10ps
`include "omrx_regs.svh"
module omrx_exec_sva (
  input wire logic                    clk,
  input wire logic                    arst_n,
  input wire omrx_pkg::omrx_avl_req_t avl_req,
  input wire omrx_pkg::omrx_avl_rsp_t avl_rsp
);
  import omrx_pkg::*;
  logic        rd_acc;
  logic        wr_acc;
  logic        in_ld;
  logic        in_or;
  logic        in_ret;
  logic [4:0]  laddr_reg;
  logic [13:0] ldat_reg;
  logic [12:0] top_reg;
  logic [7:0]  rd8;
  assign rd_acc = avl_req.read & ~avl_rsp.waitrequest;
  assign wr_acc = avl_req.write & ~avl_rsp.waitrequest;
  assign rd8 = avl_rsp.readdata[7:0];
  assign in_ld = laddr_reg == `OMRX_OFF_INSTR &&
    (ldat_reg & `OMRX_MASK_LD_LIT) == `OMRX_MATCH_LD_LIT;
  assign in_or = laddr_reg == `OMRX_OFF_INSTR &&
    (ldat_reg & `OMRX_MASK_OR_LIT) == `OMRX_MATCH_OR_LIT;
  assign in_ret = laddr_reg == `OMRX_OFF_INSTR &&
    ldat_reg == `OMRX_MATCH_RET_INT;
  // last accepted write, so reads can be tied to the instruction before
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      laddr_reg <= 5'h1c;
      ldat_reg  <= 14'h0000;
    end else if (wr_acc) begin
      laddr_reg <= avl_req.address;
      ldat_reg  <= avl_req.writedata[13:0];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      top_reg <= 13'h0000;
    end else if (wr_acc && avl_req.address == `OMRX_OFF_STACK_TOP) begin
      top_reg <= avl_req.writedata[12:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wait_one_a: assert property ((avl_req.read | avl_req.write) &&
    avl_rsp.waitrequest |=> !avl_rsp.waitrequest)
    else $error("waitrequest not low after one cycle");
  wait_pulse_a: assert property (!avl_rsp.waitrequest |=> avl_rsp.waitrequest)
    else $error("waitrequest low too long");
  rdata_hold_a: assert property (!avl_req.read |=> $stable(avl_rsp.readdata))
    else $error("read data moved without a read");
  ld_lit_a: assert property (
    rd_acc && avl_req.address == `OMRX_OFF_WORK && in_ld
    |-> rd8 == ldat_reg[7:0]) else $error("load literal value wrong");
  or_ff_a: assert property (
    rd_acc && avl_req.address == `OMRX_OFF_WORK && in_or &&
    ldat_reg[7:0] == 8'hff |-> rd8 == 8'hff) else $error("or literal wrong");
  or_nz_a: assert property (
    rd_acc && avl_req.address == `OMRX_OFF_STATUS && in_or &&
    ldat_reg[7:0] != 8'h00 |-> !avl_rsp.readdata[0])
    else $error("zero flag set on nonzero result");
  ret_inten_a: assert property (
    rd_acc && avl_req.address == `OMRX_OFF_STATUS && in_ret
    |-> avl_rsp.readdata[2]) else $error("interrupt enable not set");
  ret_pc_a: assert property (
    rd_acc && avl_req.address == `OMRX_OFF_PC && in_ret
    |-> avl_rsp.readdata[12:0] == top_reg) else $error("pc not from stack");
  cover property (rd_acc && in_ld);
  cover property (rd_acc && in_ret);
  cover property (wr_acc && avl_req.address == `OMRX_OFF_INSTR);
endmodule
bind omrx_exec omrx_exec_sva i_omrx_exec_sva (.clk(clk), .arst_n(arst_n),
  .avl_req(avl_req), .avl_rsp(avl_rsp));

/* testbench/omrx_exec_tb.sv */
// self-checking bench for the execution block over its avalon port
// assumes the package, the block and its checker are compiled first
`timescale 1ns/10ps
`include "omrx_regs.svh"
module omrx_exec_tb;
  import omrx_pkg::*;
  localparam logic [4:0] a_work = `OMRX_OFF_WORK;
  localparam logic [4:0] a_stat = `OMRX_OFF_STATUS;
  localparam logic [4:0] a_fa = `OMRX_OFF_FADDR;
  localparam logic [4:0] a_fd = `OMRX_OFF_FDATA;
  logic          clk;
  logic          arst_n;
  omrx_avl_req_t req;
  omrx_avl_rsp_t rsp;
  int            num_errors;
  int            samples_checked;
  omrx_exec i_omrx_exec (.clk(clk), .arst_n(arst_n), .avl_req(req),
    .avl_rsp(rsp));
  always #10 clk = ~clk;
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    req <= '{read: ~w, write: w, address: a, writedata: d};
    do @(posedge clk); while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req <= '0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    samples_checked++;
    if (q !== e) begin
      num_errors++;
      $display("mismatch at %0t: addr %h got %h exp %h", $time, a, q, e);
    end
  endtask
  task automatic ex(input logic [13:0] i);
    wr(`OMRX_OFF_INSTR, {18'h0, i});
  endtask
  task automatic t_lit;
    rc(a_work, 32'h0);
    rc(a_stat, 32'h0);
    rc(`OMRX_OFF_PC, 32'h0);
    rc(5'h1c, 32'h0);
    wr(a_stat, 32'h2);
    ex(14'h305a);
    rc(a_work, 32'h5a);
    ex(14'h3300);
    rc(a_work, 32'h0);
    rc(a_stat, 32'h2);
    ex(14'h3800);
    rc(a_stat, 32'h3);
    ex(14'h3881);
    rc(a_work, 32'h81);
    rc(a_stat, 32'h2);
    ex(14'h38ff);
    rc(a_work, 32'hff);
    $display("test literal done");
  endtask
  task automatic t_file;
    wr(a_fa, 32'h7f);
    wr(a_fd, 32'h40);
    ex(14'h300c);
    ex(14'h047f);
    rc(a_work, 32'h4c);
    rc(a_fd, 32'h40);
    ex(14'h04ff);
    rc(a_fd, 32'h4c);
    ex(14'h3011);
    ex(14'h00ff);
    rc(a_fd, 32'h11);
    rc(a_stat, 32'h2);
    ex(14'h3000);
    ex(14'h087f);
    rc(a_work, 32'h11);
    rc(a_stat, 32'h2);
    wr(a_fa, 32'h0);
    wr(a_fd, 32'h0);
    ex(14'h0880);
    rc(a_stat, 32'h3);
    rc(a_work, 32'h11);
    $display("test file done");
  endtask
  task automatic t_rot;
    wr(a_fa, 32'h5);
    wr(a_fd, 32'h81);
    ex(14'h0d85);
    rc(a_fd, 32'h03);
    rc(a_stat, 32'h3);
    ex(14'h0d05);
    rc(a_work, 32'h07);
    rc(a_stat, 32'h1);
    rc(a_fd, 32'h03);
    $display("test rotate done");
  endtask
  task automatic t_ret;
    wr(`OMRX_OFF_STACK_TOP, 32'h1abc);
    wr(a_stat, 32'h3);
    ex(14'h0009);
    rc(`OMRX_OFF_PC, 32'h1abc);
    rc(a_stat, 32'h7);
    rc(a_work, 32'h07);
    ex(14'h0000);
    rc(`OMRX_OFF_PC, 32'h1abd);
    rc(a_stat, 32'h7);
    ex(14'h3fff);
    rc(`OMRX_OFF_INSTR, 32'h3fff);
    rc(`OMRX_OFF_PC, 32'h1abe);
    rc(a_stat, 32'hf);
    wr(a_stat, 32'h8);
    rc(a_stat, 32'h0);
    $display("test return done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    req = '0;
    num_errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_lit;
    t_file;
    t_rot;
    t_ret;
    test_done;
  end
  initial begin
    #20000;
    num_errors++;
    test_done;
  end
endmodule
